// ==== bench/owt_core_test.sv ====
// Self-checking testbench for the operating watchdog timer core
`timescale 1ns/100ps
module owt_core_test;
   // Clock, reset and APB
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [19:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   // System events, modes and outputs
   logic        internal_reset;
   logic        reset_vector_fetch;
   logic        stop_instr;
   logic        stop_exit;
   logic        monitor_mode;
   logic        break_state;
   logic        rst_pin_high_voltage;
   logic        irq_pin_high_voltage;
   logic        system_reset;
   logic        rst_pin_o;
   logic        rst_pin_oe;
   logic        event_irq;
   // Bench state
   int          mismatches  = 0;
   int          check_count = 0;
   logic [31:0] rd;
   logic        err;
   int          n;

   owt_core owt_core_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .internal_reset(internal_reset),
      .reset_vector_fetch(reset_vector_fetch), .stop_instr(stop_instr),
      .stop_exit(stop_exit), .monitor_mode(monitor_mode), .break_state(break_state),
      .rst_pin_high_voltage(rst_pin_high_voltage),
      .irq_pin_high_voltage(irq_pin_high_voltage), .system_reset(system_reset),
      .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .event_irq(event_irq));

   // Free-running 250 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cycles(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // One APB transfer; entered and left just after a rising edge
   task automatic apb(input logic wr, input logic [17:0] idx, input logic [31:0] wd);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         mismatches++;
         final_report();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Counts edges until a system reset is seen, at most lim
   task automatic wait_reset(input int lim);
      n = 0;
      while (system_reset !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic fresh_start;
      internal_reset <= 1'b1;
      @(posedge pclk);
      internal_reset <= 1'b0;
   endtask

   task automatic t_regs;
      apb(1'b0, owt_pkg::IDX_CTRL, 32'h0);
      check(rd, {29'h0, owt_pkg::CTRL_RESET});
      apb(1'b0, owt_pkg::IDX_STATUS, 32'h0);
      check(rd, {30'h0, owt_pkg::ST_RESET});
      apb(1'b0, owt_pkg::IDX_MASK, 32'h0);
      check(rd, {30'h0, owt_pkg::MASK_RESET});
      apb(1'b0, owt_pkg::IDX_SERVICE, 32'h0);
      check(rd, {24'h0, owt_pkg::VECTOR_LOW});
      apb(1'b0, 18'h00010, 32'h0);
      check({err, rd[30:0]}, 32'h80000000);
      apb(1'b1, owt_pkg::IDX_COUNT, 32'h0000ffff);
      check({31'h0, err}, 32'h1);
      apb(1'b1, owt_pkg::IDX_CTRL, 32'h00000007);
      apb(1'b0, owt_pkg::IDX_CTRL, 32'h0);
      check(rd, 32'h00000007);
      // Byte lane 0 off: the option write must not land
      pstrb <= 4'he;
      apb(1'b1, owt_pkg::IDX_CTRL, 32'h00000000);
      pstrb <= 4'hf;
      apb(1'b0, owt_pkg::IDX_CTRL, 32'h0);
      check(rd, 32'h00000007);
   endtask

   // Short timeout, pin stretch, cause flag and the interrupt line
   task automatic t_timeout;
      int w;
      apb(1'b1, owt_pkg::IDX_CTRL, 32'h00000002);
      apb(1'b1, owt_pkg::IDX_MASK, 32'h00000000);
      fresh_start();
      wait_reset(9000);
      check({31'h0, n > 8170 && n < 8186}, 32'h1);
      check({30'h0, rst_pin_oe, rst_pin_o}, 32'h2);
      w = 1;
      forever begin
         @(posedge pclk);
         if (rst_pin_oe !== 1'b1 || w >= 100) break;
         w++;
      end
      check(w, owt_pkg::PIN_LOW_CYCLES);
      check({31'h0, event_irq}, 32'h0);
      apb(1'b0, owt_pkg::IDX_STATUS, 32'h0);
      check(rd & 32'h1, 32'h1);
      apb(1'b1, owt_pkg::IDX_MASK, 32'h00000001);
      cycles(2);
      check({31'h0, event_irq}, 32'h1);
      apb(1'b1, owt_pkg::IDX_STATUS, 32'h00000001);
      cycles(2);
      check({31'h0, event_irq}, 32'h0);
      apb(1'b0, owt_pkg::IDX_STATUS, 32'h0);
      check(rd & 32'h1, 32'h0);
   endtask

   // A service write mid-period restarts the timeout
   task automatic t_service;
      fresh_start();
      cycles(6000);
      apb(1'b1, owt_pkg::IDX_SERVICE, 32'h000000a5);
      wait_reset(6000);
      check(n, 6000);
      apb(1'b0, owt_pkg::IDX_STATUS, 32'h0);
      check(rd & 32'h2, 32'h2);
      wait_reset(3000);
      check({31'h0, n > 2100 && n < 2200}, 32'h1);
      apb(1'b1, owt_pkg::IDX_STATUS, 32'h00000003);
   endtask

   task automatic t_disable;
      apb(1'b1, owt_pkg::IDX_CTRL, 32'h00000003);
      fresh_start();
      wait_reset(9000);
      check(n, 9000);
      apb(1'b1, owt_pkg::IDX_CTRL, 32'h00000002);
   endtask

   // Test voltage table: hold, monitor, break, reset-pin, irq-pin
   task automatic t_hold;
      localparam logic [29:0] TBL = {5'b11010, 5'b11001, 5'b10110,
                                     5'b00101, 5'b01000, 5'b00010};
      logic [4:0] e;
      for (int i = 0; i < 6; i++) begin
         e = TBL[i*5 +: 5];
         {monitor_mode, break_state, rst_pin_high_voltage, irq_pin_high_voltage} <= e[3:0];
         cycles(40);
         apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
         check({31'h0, rd[17:0] == 18'h0}, {31'h0, e[4]});
         {monitor_mode, break_state, rst_pin_high_voltage, irq_pin_high_voltage} <= 4'h0;
         @(posedge pclk);
      end
   endtask

   task automatic t_stop;
      logic [31:0] a;
      fresh_start();
      cycles(100);
      stop_instr <= 1'b1;
      @(posedge pclk);
      stop_instr <= 1'b0;
      apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
      a = rd;
      cycles(20);
      apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
      check({31'h0, rd[31] == 1'b0 && rd[17:0] != a[17:0]}, 32'h1);
      apb(1'b1, owt_pkg::IDX_CTRL, 32'h00000006);
      stop_instr <= 1'b1;
      @(posedge pclk);
      stop_instr <= 1'b0;
      cycles(4);
      apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
      a = rd;
      check({a[31], 19'h0, a[11:0]}, 32'h80000000);
      cycles(50);
      apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
      check(rd, a);
      stop_exit <= 1'b1;
      @(posedge pclk);
      stop_exit <= 1'b0;
      cycles(20);
      apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
      check({31'h0, rd[31] == 1'b0 && rd[11:0] != 12'h0}, 32'h1);
      apb(1'b1, owt_pkg::IDX_CTRL, 32'h00000002);
   endtask

   // Vector fetch clears the prescaler only; internal reset clears both
   task automatic t_clears;
      fresh_start();
      cycles(5000);
      reset_vector_fetch <= 1'b1;
      @(posedge pclk);
      reset_vector_fetch <= 1'b0;
      apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
      check({31'h0, rd[17:12] == 6'h01 && rd[11:0] < 12'h010}, 32'h1);
      cycles(300);
      apb(1'b1, owt_pkg::IDX_SERVICE, 32'h00000000);
      apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
      check({31'h0, rd[17:0] < 18'h00020}, 32'h1);
      cycles(300);
      fresh_start();
      apb(1'b0, owt_pkg::IDX_COUNT, 32'h0);
      check({31'h0, rd[17:0] < 18'h00010}, 32'h1);
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge pclk);
      mismatches++;
      final_report();
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      {internal_reset, reset_vector_fetch, stop_instr, stop_exit} = 4'h0;
      {monitor_mode, break_state, rst_pin_high_voltage, irq_pin_high_voltage} = 4'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_timeout();
      t_service();
      t_disable();
      t_hold();
      t_stop();
      t_clears();
      final_report();
   end
endmodule

// ==== logic/owt_core.sv ====
// Operating watchdog timer: prescaler, watchdog counter, reset issue and APB registers
//
// Contract
// - Watchdog is a 6-bit counter fed by a 12-bit prescaler, crystal clocked.
// - Unserviced, reset after 2^13-2^4 (short) or 2^18-2^4 crystal cycles.
// - Any write to the service location clears watchdog and prescaler bits 11..4.
// - Reading the service location returns the reset vector low byte, not state.
// - Timeout drives reset pin low 32 cycles and sets the cause flag.
// - In monitor mode, high voltage on reset or irq pin disables the watchdog.
// - In break state, high voltage on the reset pin disables the watchdog.
// - STOP clears the whole prescaler and halts counting until stop exits.
// - Any internal reset clears prescaler and watchdog counter.
// - A reset vector fetch clears the prescaler.
// - The disable option suppresses all watchdog resets.
// - The watchdog never requests a CPU interrupt; timeout only resets. Here a timeout also raises event_irq when mask bit 0 is set.
// - Counting continues in wait mode.
// - STOP takes effect only when the stop-enable option is set.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
module owt_core (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [19:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // System events
   input  wire logic        internal_reset,
   input  wire logic        reset_vector_fetch,
   input  wire logic        stop_instr,
   input  wire logic        stop_exit,
   // Test voltage and mode inputs
   input  wire logic        monitor_mode,
   input  wire logic        break_state,
   input  wire logic        rst_pin_high_voltage,
   input  wire logic        irq_pin_high_voltage,
   // Reset outputs
   output logic             system_reset,
   output logic             rst_pin_o,
   output logic             rst_pin_oe,
   // Event summary line
   output logic             event_irq
);

   // Registers
   logic [owt_pkg::PRESC_W-1:0]   presc_r;
   logic [owt_pkg::WDOG_W-1:0]    wdog_r;
   logic [2:0]                    ctrl_r;
   logic [owt_pkg::ST_W-1:0]      status_r;
   logic [owt_pkg::ST_W-1:0]      status_nxt;
   logic [owt_pkg::ST_W-1:0]      mask_r;
   logic                          stopped_r;
   logic                          sys_reset_r;
   logic                          irq_r;
   logic                          pready_r;
   logic                          pslverr_r;
   logic [31:0]                   prdata_r;
   logic                          pin_out_r;

   // Decoded controls
   logic [owt_pkg::IDX_W-1:0]     idx;
   logic                          setup;
   logic                          wr_acc;
   logic                          svc_wr;
   logic                          ctrl_wr;
   logic                          status_wr;
   logic                          mask_wr;
   logic                          hv_hold;
   logic                          counting;
   logic                          stop_take;
   logic                          timeout_hit;
   logic                          fire;
   logic [owt_pkg::ELAPSED_W-1:0] elapsed;
   logic                          pin_low;

   // Timeout limit for the selected option
   function automatic logic [17:0] owt_limit(input logic short_sel);
      owt_limit = short_sel ? owt_pkg::LIMIT_SHORT : owt_pkg::LIMIT_LONG;
   endfunction

   // Word index decode shared by read and write paths
   function automatic logic is_mapped(input logic [17:0] i);
      is_mapped = (i == owt_pkg::IDX_CTRL)   || (i == owt_pkg::IDX_STATUS) ||
                  (i == owt_pkg::IDX_MASK)   || (i == owt_pkg::IDX_COUNT)  ||
                  (i == owt_pkg::IDX_SERVICE);
   endfunction

   // Bus phase decode; a write lands only at the completing access edge
   assign idx       = paddr[19:2];
   assign setup     = psel && !penable;
   assign wr_acc    = psel && penable && pready_r && pwrite && !pslverr_r;
   assign svc_wr    = wr_acc && (idx == owt_pkg::IDX_SERVICE);
   assign ctrl_wr   = wr_acc && (idx == owt_pkg::IDX_CTRL) && pstrb[0];
   assign status_wr = wr_acc && (idx == owt_pkg::IDX_STATUS) && pstrb[0];
   assign mask_wr   = wr_acc && (idx == owt_pkg::IDX_MASK) && pstrb[0];

   // High test voltage holds the watchdog off in monitor or break state
   assign hv_hold = (monitor_mode && (rst_pin_high_voltage || irq_pin_high_voltage)) ||
                    (break_state && rst_pin_high_voltage);

   // Wait mode has no input here: only stop or test voltage halts counting
   assign counting    = !stopped_r && !hv_hold;
   assign stop_take   = stop_instr && ctrl_r[owt_pkg::CTRL_STOP_EN];
   assign elapsed     = {wdog_r, presc_r};
   assign timeout_hit = counting && (elapsed == owt_limit(ctrl_r[owt_pkg::CTRL_SHORT]) - 18'h1);
   // Disable option lets the counter run but never lets it reset the system
   assign fire        = timeout_hit && !ctrl_r[owt_pkg::CTRL_DISABLE];

   // Prescaler: free running on the crystal clock, cleared by several sources
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_r <= '0;
      end else if (internal_reset || timeout_hit || stop_take || reset_vector_fetch ||
                   hv_hold) begin
         presc_r <= '0;
      end else if (svc_wr) begin
         presc_r <= {{(owt_pkg::PRESC_SVC_HI - owt_pkg::PRESC_SVC_LO + 1){1'b0}},
                     presc_r[owt_pkg::PRESC_SVC_LO-1:0]};
      end else if (counting) begin
         presc_r <= presc_r + 1'b1;
      end
   end

   // Watchdog counter advances on each prescaler wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdog_r <= '0;
      end else if (internal_reset || timeout_hit || svc_wr || hv_hold) begin
         wdog_r <= '0;
      end else if (counting && (presc_r == {owt_pkg::PRESC_W{1'b1}}) &&
                   !stop_take && !reset_vector_fetch) begin
         wdog_r <= wdog_r + 1'b1;
      end
   end

   // Stop state gates the crystal clock off the counters until stop exits or an internal reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stopped_r <= 1'b0;
      end else if (stop_exit || internal_reset) begin
         stopped_r <= 1'b0;
      end else if (stop_take) begin
         stopped_r <= 1'b1;
      end
   end

   // System reset is a registered one-cycle pulse, so no glitch from the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_reset_r <= 1'b0;
      end else begin
         sys_reset_r <= fire;
      end
   end

   // Reset pin held low through the stretcher; pin output level is always low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_r <= 1'b0;
      end else begin
         pin_out_r <= 1'b0;
      end
   end

   owt_pin_stretch owt_pin_stretch_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .trigger (fire),
      .pin_low (pin_low)
   );

   // Mask option register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= owt_pkg::CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_r <= pwdata[2:0];
      end
   end

   // Sticky status: hardware set wins over a write-one clear in the same cycle
   always_comb begin
      status_nxt = status_r;
      if (status_wr) begin
         status_nxt = status_r & ~pwdata[owt_pkg::ST_W-1:0];
      end
      if (fire) begin
         status_nxt[owt_pkg::ST_CAUSE] = 1'b1;
      end
      if (svc_wr) begin
         status_nxt[owt_pkg::ST_SERVICED] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= owt_pkg::ST_RESET;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= owt_pkg::MASK_RESET;
      end else if (mask_wr) begin
         mask_r <= pwdata[owt_pkg::ST_W-1:0];
      end
   end

   // Event line for a system monitor; a timeout also raises it, through the cause flag, when mask bit 0 is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(status_nxt & mask_r);
      end
   end

   // APB answer: ready one cycle after setup, data and error prepared at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= owt_pkg::READ_ZERO;
      end else if (setup) begin
         pready_r  <= 1'b1;
         pslverr_r <= !is_mapped(idx) || (pwrite && idx == owt_pkg::IDX_COUNT);
         prdata_r  <= owt_pkg::READ_ZERO;
         if (!pwrite) begin
            unique case (idx)
               owt_pkg::IDX_CTRL:    prdata_r <= {29'h0, ctrl_r};
               owt_pkg::IDX_STATUS:  prdata_r <= {30'h0, status_r};
               owt_pkg::IDX_MASK:    prdata_r <= {30'h0, mask_r};
               owt_pkg::IDX_COUNT:   prdata_r <= {stopped_r, 13'h0, elapsed};
               owt_pkg::IDX_SERVICE: prdata_r <= {24'h0, owt_pkg::VECTOR_LOW};
               default:              prdata_r <= owt_pkg::READ_ZERO;
            endcase
         end
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= owt_pkg::READ_ZERO;
      end
   end

   assign pready       = pready_r;
   assign prdata       = prdata_r;
   assign pslverr      = pslverr_r;
   assign system_reset = sys_reset_r;
   assign rst_pin_o    = pin_out_r;
   assign rst_pin_oe   = pin_low;
   assign event_irq    = irq_r;

   // Checks

   property p_timeout_reset;
      @(posedge pclk) disable iff (!presetn)
      (timeout_hit && !ctrl_r[owt_pkg::CTRL_DISABLE]) |=> system_reset ##1 !system_reset;
   endproperty
   a_timeout_reset: assert property (p_timeout_reset)
      else $error("timeout did not give a one-cycle system reset");

   property p_short_limit;
      @(posedge pclk) disable iff (!presetn)
      (counting && ctrl_r[owt_pkg::CTRL_SHORT] && elapsed == 18'h01fef) |-> timeout_hit;
   endproperty
   a_short_limit: assert property (p_short_limit)
      else $error("short timeout not at 2^13-2^4");

   property p_service_clear;
      @(posedge pclk) disable iff (!presetn)
      (svc_wr && !internal_reset) |=> (wdog_r == '0) && (presc_r[11:4] == 8'h00);
   endproperty
   a_service_clear: assert property (p_service_clear)
      else $error("service write did not clear the counters");

   property p_service_read;
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == owt_pkg::IDX_SERVICE) |=> prdata == 32'h0000005a;
   endproperty
   a_service_read: assert property (p_service_read)
      else $error("service read did not return the vector low byte");

   property p_cause_and_pin;
      @(posedge pclk) disable iff (!presetn)
      fire |=> status_r[owt_pkg::ST_CAUSE] && rst_pin_oe && !rst_pin_o;
   endproperty
   a_cause_and_pin: assert property (p_cause_and_pin)
      else $error("timeout did not set cause flag and drive pin");

   property p_monitor_hold;
      @(posedge pclk) disable iff (!presetn)
      (monitor_mode && (rst_pin_high_voltage || irq_pin_high_voltage)) |=>
         (wdog_r == '0) && !system_reset;
   endproperty
   a_monitor_hold: assert property (p_monitor_hold)
      else $error("watchdog active under monitor test voltage");

   property p_break_hold;
      @(posedge pclk) disable iff (!presetn)
      (break_state && rst_pin_high_voltage) |=> (presc_r == '0) && !system_reset;
   endproperty
   a_break_hold: assert property (p_break_hold)
      else $error("watchdog active in break under test voltage");

   property p_stop_halts;
      @(posedge pclk) disable iff (!presetn)
      (stop_take && !stop_exit && !internal_reset) |=> (presc_r == '0) && stopped_r;
   endproperty
   a_stop_halts: assert property (p_stop_halts)
      else $error("stop did not clear the prescaler and enter stop");

   // Only explicit clears may move the count while the clock is gated
   property p_stop_frozen;
      @(posedge pclk) disable iff (!presetn)
      (stopped_r && !stop_exit && !internal_reset && !svc_wr && !hv_hold) |=> $stable(elapsed);
   endproperty
   a_stop_frozen: assert property (p_stop_frozen)
      else $error("count moved while stopped");

   property p_internal_reset;
      @(posedge pclk) disable iff (!presetn)
      internal_reset |=> elapsed == '0;
   endproperty
   a_internal_reset: assert property (p_internal_reset)
      else $error("internal reset did not clear the counters");

   property p_vector_fetch;
      @(posedge pclk) disable iff (!presetn)
      reset_vector_fetch |=> presc_r == '0;
   endproperty
   a_vector_fetch: assert property (p_vector_fetch)
      else $error("vector fetch did not clear the prescaler");

   property p_disable_option;
      @(posedge pclk) disable iff (!presetn)
      $past(ctrl_r[owt_pkg::CTRL_DISABLE]) |-> !system_reset;
   endproperty
   a_disable_option: assert property (p_disable_option)
      else $error("reset issued while disable option set");

   property p_stop_gated;
      @(posedge pclk) disable iff (!presetn)
      (stop_instr && !ctrl_r[owt_pkg::CTRL_STOP_EN] && !stopped_r) |=> !stopped_r;
   endproperty
   a_stop_gated: assert property (p_stop_gated)
      else $error("stop took effect without stop enable");

endmodule

// ==== logic/owt_pin_stretch.sv ====
// Stretcher that holds the open-drain reset pin low for a fixed number of cycles
`timescale 1ns/100ps
module owt_pin_stretch (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Trigger and pin enable
   input  wire logic trigger,
   output logic      pin_low
);

   logic [owt_pkg::PIN_CNT_W-1:0] cnt_r;
   logic                          active_r;

   // Load on trigger, count down while driving; last count releases the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r    <= '0;
         active_r <= 1'b0;
      end else if (trigger) begin
         cnt_r    <= owt_pkg::PIN_CNT_LOAD;
         active_r <= 1'b1;
      end else if (active_r) begin
         if (cnt_r == '0) begin
            active_r <= 1'b0;
         end else begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   assign pin_low = active_r;

   property p_pin_low_32;
      @(posedge pclk) disable iff (!presetn)
      $rose(active_r) |-> ##31 active_r ##1 !active_r;
   endproperty
   a_pin_low_32: assert property (p_pin_low_32)
      else $error("reset pin not held low for exactly 32 cycles");

endmodule

// ==== logic/owt_pkg.sv ====
// Constants for the operating watchdog timer: map, fields, reset values and timing
package owt_pkg;

   // Bus geometry
   localparam int          ADDR_W          = 20;
   localparam int          IDX_W           = 18;
   localparam int          DATA_W          = 32;

   // Register indexes; byte address is four times the index
   localparam logic [17:0] IDX_CTRL        = 18'h00000;
   localparam logic [17:0] IDX_STATUS      = 18'h00001;
   localparam logic [17:0] IDX_MASK        = 18'h00002;
   localparam logic [17:0] IDX_COUNT       = 18'h00003;
   localparam logic [17:0] IDX_SERVICE     = 18'h0ffff;

   // Control register fields (mask options)
   localparam int          CTRL_DISABLE    = 0;
   localparam int          CTRL_SHORT      = 1;
   localparam int          CTRL_STOP_EN    = 2;
   localparam logic [2:0]  CTRL_RESET      = 3'h0;

   // Status and mask fields
   localparam int          ST_CAUSE        = 0;
   localparam int          ST_SERVICED     = 1;
   localparam int          ST_W            = 2;
   localparam logic [1:0]  ST_RESET        = 2'h0;
   localparam logic [1:0]  MASK_RESET      = 2'h0;

   // Count register: stopped flag position
   localparam int          CNT_STOPPED     = 31;

   // Counter widths and the part of the prescaler cleared by service
   localparam int          PRESC_W         = 12;
   localparam int          WDOG_W          = 6;
   localparam int          ELAPSED_W       = 18;
   localparam int          PRESC_SVC_HI    = 11;
   localparam int          PRESC_SVC_LO    = 4;

   // Timeouts in crystal cycles: 2^18 - 2^4 and 2^13 - 2^4
   localparam logic [17:0] LIMIT_LONG      = 18'h3fff0;
   localparam logic [17:0] LIMIT_SHORT     = 18'h01ff0;

   // Reset pin low time in crystal cycles
   localparam int          PIN_LOW_CYCLES  = 32;
   localparam int          PIN_CNT_W       = 5;
   localparam logic [4:0]  PIN_CNT_LOAD    = 5'h1f;

   // Low byte of the reset vector seen at the service location; value arbitrary
   localparam logic [7:0]  VECTOR_LOW      = 8'h5a;

   // Read value for unmapped words, and the data bus value during write transfers
   localparam logic [31:0] READ_ZERO       = 32'h00000000;

endpackage
